// >>> hdl/gpcp_defs.svh
// register offsets, field positions, reset values and widths of the pin configuration block
`ifndef GPCP_DEFS_SVH
`define GPCP_DEFS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define GPCP_OFS_P0_PIN5_CFG 32'h5000_3010
`define GPCP_OFS_P0_PIN6_CFG 32'h5000_3012
`define GPCP_OFS_P0_PIN7_CFG 32'h5000_3014
`define GPCP_OFS_P1_LEVEL 32'h5000_3020
`define GPCP_OFS_P1_SETTER 32'h5000_3022
`define GPCP_OFS_P1_CLEARER 32'h5000_3024
`define GPCP_OFS_P1_PIN0_CFG 32'h5000_3026
`define GPCP_OFS_P1_PIN1_CFG 32'h5000_3028
`define GPCP_OFS_P1_PIN2_CFG 32'h5000_302a
`define GPCP_OFS_P1_PIN3_CFG 32'h5000_302c
`define GPCP_OFS_P1_PIN4_CFG 32'h5000_302e

// ****************************************
// field positions
// ****************************************
`define GPCP_PULL_HI 9
`define GPCP_PULL_LO 8
`define GPCP_FUNC_HI 4
`define GPCP_FUNC_LO 0
`define GPCP_LEVEL_HI 7
`define GPCP_LEVEL_LO 0

// ****************************************
// reset values and sizes
// ****************************************
`define GPCP_RST_PULL 2'h2
`define GPCP_RST_FUNC 5'h00
`define GPCP_RST_LEVEL 8'h20
`define GPCP_RST_RDATA 16'h0000
`define GPCP_NUM_PINS 8
`define GPCP_NUM_FUNCS 32
`define GPCP_FUNC_PORT 5'h00

`endif

// >>> hdl/gpcp_pkg.sv
// types shared by the pin configuration block
package gpcp_pkg;

  // ****************************************
  // pull and direction selection
  // ****************************************
  typedef enum logic [1:0] {
    GPCP_IN_FLOAT = 2'h0,
    GPCP_IN_PULLUP = 2'h1,
    GPCP_IN_PULLDOWN = 2'h2,
    GPCP_OUT_DRIVE = 2'h3
  } gpcp_pull_type;

  typedef logic [4:0] gpcp_func_type;
  typedef logic [7:0] gpcp_level_type;
  typedef logic [15:0] gpcp_word_type;

endpackage : gpcp_pkg

// >>> hdl/gpcp_pad_cell.sv
// pad control mapping of one pin from its configuration
`timescale 1ns/1ns
`include "gpcp_defs.svh"
module gpcp_pad_cell (
  input wire gpcp_pkg::gpcp_pull_type pull_direction_select, // pull and direction field
  input wire gpcp_pkg::gpcp_func_type pin_function_select, // pin function field
  input wire logic port_level, // port output register bit
  input wire logic [31:0] periph_drive_val, // peripheral output values by code
  input wire logic [31:0] periph_drive_en, // peripheral output enables by code
  output logic out_val, // value to the pad
  output logic out_en, // pad driver enable
  output logic pull_up, // pull-up resistor on
  output logic pull_down // pull-down resistor on
);

  // ****************************************
  // selection
  // ****************************************
  // a peripheral owns the driver only when its own enable says so
  wire is_port = (pin_function_select == `GPCP_FUNC_PORT);
  wire periph_en = periph_drive_en[pin_function_select];
  wire periph_val = periph_drive_val[pin_function_select];
  wire drive_mode = (pull_direction_select == gpcp_pkg::GPCP_OUT_DRIVE);

  // resistors follow the field whenever nothing drives the pin
  assign out_en = is_port ? drive_mode : periph_en;
  assign out_val = is_port ? port_level : periph_val;
  assign pull_up = !out_en && (pull_direction_select == gpcp_pkg::GPCP_IN_PULLUP);
  assign pull_down = !out_en && (pull_direction_select == gpcp_pkg::GPCP_IN_PULLDOWN);

endmodule : gpcp_pad_cell

// >>> hdl/gpcp_top.sv
// pad configuration of eight pins and the second port's output data register
//
// Notes on behaviour
// R1: pull field 00 input float, 01 pull-up, 10 pull-down, 11 driven output.
// R2: every pull field resets to the pull-down input setting.
// R3: data register write loads the output register; it resets to 0x20.
// R4: data register read returns the synchronised pin levels of the port.
// R5: ones written to the set register set matching output bits only.
// R6: ones written to the clear register clear matching output bits only.
// R7: zeros written to set or clear do nothing; both read as zero.
// R8: function zero is plain port use; codes 1 to 31 connect peripherals.
// R9: a shared peripheral input comes from the lowest pin, first port first.
// R10: reserved register bits ignore writes and read back zero.
//
// pin order inside this block: 0..2 = first port pins 5..7,
// 3..7 = second port pins 0..4
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`include "gpcp_defs.svh"
module gpcp_top (
  input wire logic clock, // system clock, 250 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [31:0] reg_addr, // register byte address
  input wire logic [15:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, cycle after the strobe
  input wire logic [2:0] port0_out_level, // first port output bits 5..7
  input wire logic [2:0] port0_pin_in, // first port pin levels 5..7
  input wire logic [7:0] port1_pin_in, // second port pin levels
  input wire logic [31:0] periph_drive_val, // peripheral outputs by code
  input wire logic [31:0] periph_drive_en, // peripheral output enables by code
  output logic [7:0] pad_out, // pad output values
  output logic [7:0] pad_oe, // pad driver enables
  output logic [7:0] pad_pull_up, // pull-up enables
  output logic [7:0] pad_pull_down, // pull-down enables
  output logic [7:0] port1_out_level, // second port output register
  output logic [31:0] periph_in // pin levels routed to peripheral inputs
);

  // ****************************************
  // functions
  // ****************************************
  // offset of the configuration register of one pin
  function automatic logic [31:0] cfg_offset(input int unsigned idx);
    logic [31:0] ofs;
    ofs = `GPCP_OFS_P0_PIN5_CFG;
    case (idx)
      1: ofs = `GPCP_OFS_P0_PIN6_CFG;
      2: ofs = `GPCP_OFS_P0_PIN7_CFG;
      3: ofs = `GPCP_OFS_P1_PIN0_CFG;
      4: ofs = `GPCP_OFS_P1_PIN1_CFG;
      5: ofs = `GPCP_OFS_P1_PIN2_CFG;
      6: ofs = `GPCP_OFS_P1_PIN3_CFG;
      7: ofs = `GPCP_OFS_P1_PIN4_CFG;
      default: ofs = `GPCP_OFS_P0_PIN5_CFG;
    endcase
    return ofs;
  endfunction : cfg_offset

  // one-hot hit vector of the configuration registers
  function automatic logic [7:0] cfg_hits(input logic [31:0] addr);
    logic [7:0] hit;
    hit = 8'h00;
    for (int i = 0; i < `GPCP_NUM_PINS; i++) begin
      hit[i] = (addr == cfg_offset(i));
    end
    return hit;
  endfunction : cfg_hits

  // packs a configuration into its register word; reserved bits stay zero
  function automatic gpcp_pkg::gpcp_word_type cfg_word(
    input gpcp_pkg::gpcp_pull_type pull,
    input gpcp_pkg::gpcp_func_type func
  );
    gpcp_pkg::gpcp_word_type w;
    w = 16'h0000;
    w[`GPCP_PULL_HI:`GPCP_PULL_LO] = pull; // R10
    w[`GPCP_FUNC_HI:`GPCP_FUNC_LO] = func; // R10
    return w;
  endfunction : cfg_word

  // lowest pin selecting a code wins, first port pins sit lowest
  function automatic logic [31:0] route_inputs(
    input gpcp_pkg::gpcp_func_type f0, input gpcp_pkg::gpcp_func_type f1,
    input gpcp_pkg::gpcp_func_type f2, input gpcp_pkg::gpcp_func_type f3,
    input gpcp_pkg::gpcp_func_type f4, input gpcp_pkg::gpcp_func_type f5,
    input gpcp_pkg::gpcp_func_type f6, input gpcp_pkg::gpcp_func_type f7,
    input logic [7:0] lvl
  );
    logic [31:0] r;
    gpcp_pkg::gpcp_func_type f [8];
    r = 32'h0000_0000;
    f[0] = f0;
    f[1] = f1;
    f[2] = f2;
    f[3] = f3;
    f[4] = f4;
    f[5] = f5;
    f[6] = f6;
    f[7] = f7;
    for (int c = 1; c < `GPCP_NUM_FUNCS; c++) begin
      for (int i = `GPCP_NUM_PINS - 1; i >= 0; i--) begin
        if (f[i] == 5'(c)) begin
          r[c] = lvl[i]; // R9
        end
      end
    end
    return r;
  endfunction : route_inputs

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [10:0] pin_meta_r;
  logic [10:0] pin_sync_r;

  // pins are asynchronous; only the second stage is read below
  always_ff @(posedge clock) begin
    pin_meta_r <= {port1_pin_in, port0_pin_in};
    pin_sync_r <= pin_meta_r;
  end

  wire [7:0] port1_sync = pin_sync_r[10:3];
  wire [7:0] cfg_pin_sync = pin_sync_r[7:0];

  // ****************************************
  // address decode
  // ****************************************
  wire [7:0] cfg_hit = cfg_hits(reg_addr);
  wire level_hit = (reg_addr == `GPCP_OFS_P1_LEVEL);
  wire setter_hit = (reg_addr == `GPCP_OFS_P1_SETTER);
  wire clearer_hit = (reg_addr == `GPCP_OFS_P1_CLEARER);
  wire [7:0] cfg_we = cfg_hit & {8{reg_wr}};
  wire level_we = reg_wr && level_hit;
  wire setter_we = reg_wr && setter_hit;
  wire clearer_we = reg_wr && clearer_hit;
  wire [7:0] wr_bits = reg_wdata[`GPCP_LEVEL_HI:`GPCP_LEVEL_LO];

  // ****************************************
  // configuration registers
  // ****************************************
  gpcp_pkg::gpcp_pull_type cfg_pull_r [8];
  gpcp_pkg::gpcp_func_type cfg_func_r [8];

  // only the two fields are stored, so reserved bits cannot hold a write
  always_ff @(posedge clock) begin
    for (int i = 0; i < `GPCP_NUM_PINS; i++) begin
      if (sys_rst) begin
        cfg_pull_r[i] <= gpcp_pkg::gpcp_pull_type'(`GPCP_RST_PULL); // R2
        cfg_func_r[i] <= `GPCP_RST_FUNC;
      end else if (cfg_we[i]) begin
        cfg_pull_r[i] <= gpcp_pkg::gpcp_pull_type'(reg_wdata[`GPCP_PULL_HI:`GPCP_PULL_LO]); // R1
        cfg_func_r[i] <= reg_wdata[`GPCP_FUNC_HI:`GPCP_FUNC_LO]; // R8
      end
    end
  end

  // ****************************************
  // second port output register
  // ****************************************
  // the three writers are told apart by address, so at most one acts
  wire [7:0] level_nxt =
    level_we ? wr_bits : // R3
    setter_we ? (port1_out_level | wr_bits) : // R5
    clearer_we ? (port1_out_level & ~wr_bits) : // R6
    port1_out_level;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      port1_out_level <= `GPCP_RST_LEVEL; // R3
    end else begin
      port1_out_level <= level_nxt; // R7
    end
  end

  // ****************************************
  // read path
  // ****************************************
  gpcp_pkg::gpcp_word_type cfg_rd_word;
  gpcp_pkg::gpcp_word_type rdata_nxt;

  // one-hot decode lets the words be OR-ed together
  always_comb begin
    cfg_rd_word = 16'h0000;
    for (int i = 0; i < `GPCP_NUM_PINS; i++) begin
      if (cfg_hit[i]) begin
        cfg_rd_word = cfg_rd_word | cfg_word(cfg_pull_r[i], cfg_func_r[i]);
      end
    end
  end

  // set and clear registers and unmapped addresses answer zero
  assign rdata_nxt = !reg_rd ? `GPCP_RST_RDATA :
    level_hit ? {8'h00, port1_sync} : // R4
    cfg_rd_word; // R7

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= `GPCP_RST_RDATA;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ****************************************
  // pad control
  // ****************************************
  wire [7:0] port_bits = {port1_out_level[4:0], port0_out_level};
  wire [7:0] cell_out;
  wire [7:0] cell_oe;
  wire [7:0] cell_pu;
  wire [7:0] cell_pd;

  genvar g;
  generate
    for (g = 0; g < `GPCP_NUM_PINS; g++) begin : g_pad
      gpcp_pad_cell u_cell (
        .pull_direction_select(cfg_pull_r[g]),
        .pin_function_select(cfg_func_r[g]),
        .port_level(port_bits[g]),
        .periph_drive_val(periph_drive_val),
        .periph_drive_en(periph_drive_en),
        .out_val(cell_out[g]),
        .out_en(cell_oe[g]),
        .pull_up(cell_pu[g]),
        .pull_down(cell_pd[g])
      );
    end
  endgenerate

  // peripheral input routing from synchronised pin levels
  wire [31:0] periph_in_nxt = route_inputs(
    cfg_func_r[0], cfg_func_r[1], cfg_func_r[2], cfg_func_r[3],
    cfg_func_r[4], cfg_func_r[5], cfg_func_r[6], cfg_func_r[7],
    cfg_pin_sync);

  // registered pad controls cost one cycle of latency but keep pads glitch free
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pad_out <= 8'h00;
      pad_oe <= 8'h00;
      pad_pull_up <= 8'h00;
      pad_pull_down <= 8'hff;
      periph_in <= 32'h0000_0000;
    end else begin
      pad_out <= cell_out; // R1
      pad_oe <= cell_oe; // R1
      pad_pull_up <= cell_pu;
      pad_pull_down <= cell_pd;
      periph_in <= periph_in_nxt; // R8
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_cfg_write;
    reg_wr && cfg_hit[3];
  endsequence

  sequence s_cfg_readback;
    reg_rd && cfg_hit[3];
  endsequence

  a_data_write: assert property ( // R3
    level_we |=> port1_out_level == $past(wr_bits))
  else $error("data write not loaded");

  a_set_bits: assert property ( // R5
    setter_we |=> port1_out_level == ($past(port1_out_level) | $past(wr_bits)))
  else $error("set register misbehaves");

  a_clear_bits: assert property ( // R6
    clearer_we |=> port1_out_level == ($past(port1_out_level) & ~$past(wr_bits)))
  else $error("clear register misbehaves");

  a_strobe_readzero: assert property ( // R7
    reg_rd && (setter_hit || clearer_hit) |=> reg_rdata == 16'h0000)
  else $error("set or clear register read not zero");

  a_level_read: assert property ( // R4
    reg_rd && level_hit |=> reg_rdata == {8'h00, $past(port1_sync)})
  else $error("data read does not show pin levels");

  a_cfg_readback: assert property ( // R10
    s_cfg_write ##1 (s_cfg_readback and !reg_wr) |=>
      reg_rdata == ($past(reg_wdata, 2) & 16'h031f))
  else $error("configuration readback wrong");

  a_reset_values: assert property (@(posedge clock) disable iff (1'b0) // R2
    sys_rst |=> port1_out_level == `GPCP_RST_LEVEL &&
      cfg_pull_r[0] == gpcp_pkg::GPCP_IN_PULLDOWN && cfg_pull_r[7] == gpcp_pkg::GPCP_IN_PULLDOWN)
  else $error("reset values wrong");

  a_pull_up: assert property ( // R1
    cfg_pull_r[3] == gpcp_pkg::GPCP_IN_PULLUP && cfg_func_r[3] == 5'h00 |=>
      pad_pull_up[3] && !pad_pull_down[3] && !pad_oe[3])
  else $error("pull-up setting not applied");

  a_drive_out: assert property ( // R1
    cfg_pull_r[3] == gpcp_pkg::GPCP_OUT_DRIVE && cfg_func_r[3] == 5'h00 |=>
      pad_oe[3] && pad_out[3] == $past(port1_out_level[0]))
  else $error("output mode not driving data");

  a_func_prio: assert property ( // R9
    cfg_func_r[0] == 5'h09 && cfg_func_r[5] == 5'h09 |=> periph_in[9] == $past(cfg_pin_sync[0]))
  else $error("input priority wrong");

  a_periph_drive: assert property ( // R8
    cfg_func_r[4] != 5'h00 && periph_drive_en[cfg_func_r[4]] |=>
      pad_oe[4] && pad_out[4] == $past(periph_drive_val[cfg_func_r[4]]))
  else $error("peripheral not connected");

  a_pull_down: assert property ( // R1
    cfg_pull_r[3] == gpcp_pkg::GPCP_IN_PULLDOWN && cfg_func_r[3] == 5'h00 |=>
      pad_pull_down[3] && !pad_pull_up[3] && !pad_oe[3])
  else $error("pull-down setting not applied");

  a_float_input: assert property ( // R1
    cfg_pull_r[3] == gpcp_pkg::GPCP_IN_FLOAT && cfg_func_r[3] == 5'h00 |=>
      !pad_pull_up[3] && !pad_pull_down[3] && !pad_oe[3])
  else $error("floating input setting not applied");

  a_zero_bits_keep: assert property ( // R7
    setter_we || clearer_we |=>
      (port1_out_level & ~$past(wr_bits)) == ($past(port1_out_level) & ~$past(wr_bits)))
  else $error("zero bits of a set or clear write changed the port");

  a_cfg_reserved: assert property ( // R10
    reg_rd && (cfg_hit != 8'h00) |=> reg_rdata[15:10] == 6'h00 && reg_rdata[7:5] == 3'h0)
  else $error("reserved configuration bits not zero");

  a_level_hold: assert property ( // R3
    !(level_we || setter_we || clearer_we) |=> $stable(port1_out_level))
  else $error("output register changed without a write");

endmodule : gpcp_top

// >>> verification/gpcp_pin_model.sv
// board-side model of the eight pads and the three unpadded second port pins
`timescale 1ns/1ns
module gpcp_pin_model (
  input wire logic [7:0] pad_out, // pad output values
  input wire logic [7:0] pad_oe, // pad driver enables
  input wire logic [7:0] pad_pull_up, // pull-up enables
  input wire logic [7:0] pad_pull_down, // pull-down enables
  input wire logic [10:0] ext_level, // weak outside level, pads then port1 pins 5..7
  output logic [2:0] port0_pin_in, // first port levels 5..7
  output logic [7:0] port1_pin_in // second port levels
);
  logic [7:0] pin_lvl;

  // outside source is weak: the pad driver wins, then the resistors
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) begin
        pin_lvl[i] = pad_out[i];
      end else if (pad_pull_up[i]) begin
        pin_lvl[i] = 1'b1;
      end else if (pad_pull_down[i]) begin
        pin_lvl[i] = 1'b0;
      end else begin
        pin_lvl[i] = ext_level[i];
      end
    end
  end

  // pins 5..7 of the second port have no pad control in this block
  assign port0_pin_in = pin_lvl[2:0];
  assign port1_pin_in = {ext_level[10:8], pin_lvl[7:3]};
endmodule : gpcp_pin_model

// >>> verification/gpcp_top_tb.sv
// self-checking bench for the pin configuration block
`timescale 1ns/1ns
`include "gpcp_defs.svh"
module gpcp_top_tb;
  logic clock;
  logic sys_rst;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [2:0] port0_out_level;
  logic [2:0] port0_pin_in;
  logic [7:0] port1_pin_in;
  logic [31:0] periph_drive_val;
  logic [31:0] periph_drive_en;
  logic [31:0] periph_in;
  logic [7:0] pad_out;
  logic [7:0] pad_oe;
  logic [7:0] pad_pull_up;
  logic [7:0] pad_pull_down;
  logic [7:0] port1_out_level;
  logic [10:0] ext_level;
  logic [31:0] cfg_ofs [8];
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  gpcp_top gpcp_top_i (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port0_out_level(port0_out_level),
    .port0_pin_in(port0_pin_in), .port1_pin_in(port1_pin_in), .periph_drive_val(periph_drive_val),
    .periph_drive_en(periph_drive_en), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .port1_out_level(port1_out_level), .periph_in(periph_in));

  gpcp_pin_model gpcp_pin_model_i (.pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .ext_level(ext_level), .port0_pin_in(port0_pin_in),
    .port1_pin_in(port1_pin_in));

  // ****************************************
  // helpers
  // ****************************************
  // free-running 4 ns clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // hang guard, well above the fewer than two hundred cycles the run needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // write: strobe taken at the second edge, released right after it
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // write then read back with no gap between the strobes
  task automatic wr_rd(input logic [31:0] a, input logic [15:0] d, input logic [15:0] exp, input string nm);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask : wr_rd

  // read data stand only in the cycle after the taking edge
  task automatic rdc(input logic [31:0] a, input logic [15:0] exp, input string nm);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask : rdc

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    @(negedge clock);
    chk("out_level", 16'h0020, {8'h00, port1_out_level});
    chk("pull_down", 16'h00ff, {8'h00, pad_pull_down});
    for (int i = 0; i < 8; i++) begin
      rdc(cfg_ofs[i], 16'h0200, "cfg_reset");
    end
    rdc(`GPCP_OFS_P1_SETTER, 16'h0000, "setter_rd");
  endtask : t_reset

  task automatic t_cfg;
    for (int i = 0; i < 8; i++) begin
      wr_rd(cfg_ofs[i], 16'hffff, 16'h031f, "cfg_rsvd");
      wr(cfg_ofs[i], 16'h0200);
    end
    rdc(32'h5000_3016, 16'h0000, "unmapped");
  endtask : t_cfg

  task automatic t_pull;
    for (int c = 0; c < 4; c++) begin
      wr(cfg_ofs[3], {6'h00, c[1:0], 8'h00});
      repeat (3) @(negedge clock);
      chk("pull_up", {15'h0000, c == 1}, {15'h0000, pad_pull_up[3]});
      chk("pull_dn", {15'h0000, c == 2}, {15'h0000, pad_pull_down[3]});
      chk("drive_en", {15'h0000, c == 3}, {15'h0000, pad_oe[3]});
    end
    chk("drive_val", 16'h0000, {15'h0000, pad_out[3]});
    wr(cfg_ofs[0], 16'h0300);
    repeat (2) @(negedge clock);
    chk("p0_drive_en", 16'h0001, {15'h0000, pad_oe[0]});
    chk("p0_drive_val", 16'h0001, {15'h0000, pad_out[0]});
  endtask : t_pull

  // pin3 is left a driven port output, so its level follows bit 0
  task automatic t_data;
    wr(`GPCP_OFS_P1_LEVEL, 16'hff5a);
    @(negedge clock);
    chk("level_wr", 16'h005a, {8'h00, port1_out_level});
    wr(`GPCP_OFS_P1_SETTER, 16'hff81);
    @(negedge clock);
    chk("set", 16'h00db, {8'h00, port1_out_level});
    wr(`GPCP_OFS_P1_CLEARER, 16'hff0a);
    @(negedge clock);
    chk("clear", 16'h00d1, {8'h00, port1_out_level});
    rdc(`GPCP_OFS_P1_CLEARER, 16'h0000, "clearer_rd");
    ext_level <= 11'h200;
    repeat (5) @(negedge clock);
    rdc(`GPCP_OFS_P1_LEVEL, 16'h0041, "pin_levels");
  endtask : t_data

  // shared input code 9 on pin 0 and pin 5, levels set by the pulls
  task automatic t_func;
    @(posedge clock);
    periph_drive_val <= 32'h0000_0020;
    periph_drive_en <= 32'h0000_0020;
    wr(cfg_ofs[4], 16'h0205);
    repeat (2) @(negedge clock);
    chk("periph_oe", 16'h0001, {15'h0000, pad_oe[4]});
    chk("periph_val", 16'h0001, {15'h0000, pad_out[4]});
    @(posedge clock);
    periph_drive_en <= 32'h0000_0000;
    repeat (2) @(negedge clock);
    chk("periph_off", 16'h0001, {15'h0000, pad_pull_down[4]});
    wr(cfg_ofs[0], 16'h0109);
    wr(cfg_ofs[5], 16'h0209);
    repeat (5) @(negedge clock);
    chk("shared_hi", 16'h0001, {15'h0000, periph_in[9]});
    wr(cfg_ofs[0], 16'h0209);
    wr(cfg_ofs[5], 16'h0109);
    repeat (5) @(negedge clock);
    chk("shared_lo", 16'h0000, {15'h0000, periph_in[9]});
  endtask : t_func

  // main sequence
  initial begin
    cfg_ofs = '{`GPCP_OFS_P0_PIN5_CFG, `GPCP_OFS_P0_PIN6_CFG, `GPCP_OFS_P0_PIN7_CFG, `GPCP_OFS_P1_PIN0_CFG,
      `GPCP_OFS_P1_PIN1_CFG, `GPCP_OFS_P1_PIN2_CFG, `GPCP_OFS_P1_PIN3_CFG, `GPCP_OFS_P1_PIN4_CFG};
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 32'h0000_0000;
    reg_wdata = 16'h0000;
    port0_out_level = 3'h5;
    periph_drive_val = 32'h0000_0000;
    periph_drive_en = 32'h0000_0000;
    ext_level = 11'h000;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_cfg();
    t_pull();
    t_data();
    t_func();
    close_out();
  end
endmodule : gpcp_top_tb
